// ==== core/mds_defines.vh ====
`ifndef MDS_DEFINES_VH
`define MDS_DEFINES_VH

// Register byte offsets on the APB bus
`define MDS_OFS_COIL      12'h000
`define MDS_OFS_SPIN_REF  12'h004
`define MDS_OFS_SYS_CTRL  12'h008
`define MDS_OFS_SERIAL    12'h00c
`define MDS_OFS_STATUS    12'h010

// Coil-control word fields
`define MDS_DAC_LSB       0
`define MDS_DAC_MSB       7
`define MDS_GAIN_LSB      8
`define MDS_GAIN_MSB      9
`define MDS_COIL_WIDTH    10

// Spindle reference word width
`define MDS_SPIN_REF_WIDTH 12

// System-control word fields
`define MDS_SYS_BEMF_MODE   0
`define MDS_SYS_AUX_SOURCE  1
`define MDS_SYS_BRAKE       2
`define MDS_SYS_UNIPOLAR    3
`define MDS_SYS_STEP_BIT    4
`define MDS_SYS_START_SEL   5
`define MDS_SYS_COIL_EN     6
`define MDS_SYS_SPIN_EN     7
`define MDS_SYS_WIDTH       8

// Serial word routing fields
`define MDS_SER_ID_MSB    15
`define MDS_SER_ID_LSB    14
`define MDS_SER_PT_MSB    13
`define MDS_SER_PT_LSB    12
`define MDS_SER_ID_SEL    2'h0
`define MDS_PT_COIL       2'h1
`define MDS_PT_SPIN       2'h2
`define MDS_PT_SYS        2'h3

// Power-up values
`define MDS_COIL_RST      10'h000
`define MDS_SPIN_REF_RST  12'h000
`define MDS_SYS_RST       8'h00

// Commutation states 0..5
`define MDS_LAST_STATE    3'h5
`define MDS_FIRST_STATE   3'h0

// Hall decode flag for a pattern that names no state
`define MDS_HALL_BAD_BIT  3

// Status word fields
`define MDS_ST_STATE_MSB  2
`define MDS_ST_STATE_LSB  0
`define MDS_ST_HALL_BAD   3
`define MDS_ST_FAULT      4
`define MDS_ST_RETRACT    5
`define MDS_ST_GAIN_MSB   8
`define MDS_ST_GAIN_LSB   6
`define MDS_ST_HALL_MSB   11
`define MDS_ST_HALL_LSB   9
`define MDS_ST_DAC_SPIN   12

`endif

// ==== core/mds_commutation_step.v ====
`include "mds_defines.vh"

// Six-state spindle commutation counter with a direct load path for hall input
module mds_commutation_step (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Control
  input wire clear,
  input wire load,
  input wire [2:0] loadState,
  input wire advance,
  // State
  output reg [2:0] state_q
);

  reg [2:0] state_d;

  // Next state: clear beats load, load beats advance
  always @* begin
    state_d = state_q;
    if (clear) begin
      state_d = `MDS_FIRST_STATE;
    end else if (load) begin
      state_d = loadState;
    end else if (advance) begin
      if (state_q == `MDS_LAST_STATE) begin
        state_d = `MDS_FIRST_STATE; // Wrap after the sixth step
      end else begin
        state_d = state_q + 3'h1;
      end
    end
  end

  // State register
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= `MDS_FIRST_STATE;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

// ==== core/mds_motor_drive_sequencer.v ====
// Decided for this implementation: register access over APB and the placing of the registers.
`include "mds_defines.vh"

module mds_motor_drive_sequencer (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // APB slave
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Supply monitor and retract
  input wire powerGoodResetN,
  input wire retractLevelSet,
  output reg retractDriveOutputEn,
  output reg retractDriveLevel,
  output reg retractActive,
  // Position sensing
  input wire hallInputPhaseOne,
  input wire hallInputPhaseTwo,
  input wire hallInputPhaseThree,
  input wire externalCommutationPulse,
  input wire phaseCrossSignal,
  // Coil DAC and gain
  output reg [7:0] dacCode,
  output reg dacToSpindle,
  output reg gainSwitchOne,
  output reg gainSwitchTwo,
  output reg gainSwitchThree,
  // Coil bridge
  output reg coilOutputAHighOn,
  output reg coilOutputALowOn,
  output reg coilOutputBHighOn,
  output reg coilOutputBLowOn,
  // Spindle bridge, bit 0 is phase one
  output reg [2:0] spinHighOn,
  output reg [2:0] spinLowOn,
  // Center tap open-drain pin
  output reg centerTapControlOut,
  output reg centerTapControlOeN
);

  // Gain-range decode to switch closures {three, two, one}
  function [2:0] gainDecode;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: gainDecode = 3'h0;
        2'h1: gainDecode = 3'h1;
        2'h2: gainDecode = 3'h2;
        2'h3: gainDecode = 3'h4;
        default: gainDecode = 3'h0;
      endcase
    end
  endfunction

  // Hall pattern to commutation state; bit 3 flags an illegal pattern
  function [3:0] hallDecode;
    input [2:0] hall;
    begin
      case (hall)
        3'h1: hallDecode = 4'h0;
        3'h3: hallDecode = 4'h1;
        3'h2: hallDecode = 4'h2;
        3'h6: hallDecode = 4'h3;
        3'h4: hallDecode = 4'h4;
        3'h5: hallDecode = 4'h5;
        default: hallDecode = 4'h8;
      endcase
    end
  endfunction

  // Commutation state to {high[2:0], low[2:0]} driver pattern
  function [5:0] bridgeTable;
    input [2:0] state;
    begin
      case (state)
        3'h0: bridgeTable = 6'h0a;
        3'h1: bridgeTable = 6'h0c;
        3'h2: bridgeTable = 6'h14;
        3'h3: bridgeTable = 6'h11;
        3'h4: bridgeTable = 6'h21;
        3'h5: bridgeTable = 6'h22;
        default: bridgeTable = 6'h00;
      endcase
    end
  endfunction

  // Control words
  reg [`MDS_COIL_WIDTH-1:0] coilWord_q;
  reg [`MDS_COIL_WIDTH-1:0] coilWord_d;
  reg [`MDS_SPIN_REF_WIDTH-1:0] spinRef_q;
  reg [`MDS_SPIN_REF_WIDTH-1:0] spinRef_d;
  reg [`MDS_SYS_WIDTH-1:0] sysCtrl_q;
  reg [`MDS_SYS_WIDTH-1:0] sysCtrl_d;
  // Input history for edge detection and the hall status flag
  reg auxPulse_q;
  reg phaseCross_q;
  reg hallIllegal_q;
  // Bus decode
  wire wrEn;
  wire rdSetup;
  wire addrHit;
  wire serialSelected;
  wire [1:0] serialPort;
  // Mode and events
  wire fault;
  wire bemfMode;
  wire startMode;
  wire stepFall;
  wire auxRise;
  wire phaseEdge;
  wire stateAdvance;
  wire [3:0] hallState;
  wire [2:0] commState;
  wire [5:0] bridge;
  wire [2:0] gainSel;
  reg [31:0] rdMux;

  // A low power-good line is a fault and retract follows on the next clock edge
  assign fault = ~powerGoodResetN;

  // Zero-wait slave; only listed offsets answer without error
  assign pready = 1'b1;
  assign addrHit = (paddr == `MDS_OFS_COIL) || (paddr == `MDS_OFS_SPIN_REF) ||
                   (paddr == `MDS_OFS_SYS_CTRL) || (paddr == `MDS_OFS_SERIAL) ||
                   (paddr == `MDS_OFS_STATUS);
  assign pslverr = psel & penable & ~addrHit;
  assign wrEn = psel & penable & pwrite & addrHit;
  assign rdSetup = psel & ~penable & ~pwrite;

  // Serial routing word: device id in the top two bits, port select below
  assign serialSelected = (pwdata[`MDS_SER_ID_MSB:`MDS_SER_ID_LSB] == `MDS_SER_ID_SEL);
  assign serialPort = pwdata[`MDS_SER_PT_MSB:`MDS_SER_PT_LSB];

  // Next values of the control words; a retract restores power-up values
  always @* begin
    coilWord_d = coilWord_q;
    spinRef_d = spinRef_q;
    sysCtrl_d = sysCtrl_q;
    if (fault) begin
      coilWord_d = `MDS_COIL_RST;
      spinRef_d = `MDS_SPIN_REF_RST;
      sysCtrl_d = `MDS_SYS_RST;
    end else if (wrEn) begin
      case (paddr)
        `MDS_OFS_COIL: coilWord_d = pwdata[`MDS_COIL_WIDTH-1:0];
        `MDS_OFS_SPIN_REF: spinRef_d = pwdata[`MDS_SPIN_REF_WIDTH-1:0];
        `MDS_OFS_SYS_CTRL: sysCtrl_d = pwdata[`MDS_SYS_WIDTH-1:0];
        `MDS_OFS_SERIAL: begin
          // A null port or foreign id leaves every port unchanged
          if (serialSelected && serialPort == `MDS_PT_COIL) begin
            coilWord_d = pwdata[`MDS_COIL_WIDTH-1:0];
          end else if (serialSelected && serialPort == `MDS_PT_SPIN) begin
            spinRef_d = pwdata[`MDS_SPIN_REF_WIDTH-1:0];
          end else if (serialSelected && serialPort == `MDS_PT_SYS) begin
            sysCtrl_d = pwdata[`MDS_SYS_WIDTH-1:0];
          end
        end
        default: coilWord_d = coilWord_q;
      endcase
    end
  end

  // Control word registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      coilWord_q <= `MDS_COIL_RST;
      spinRef_q <= `MDS_SPIN_REF_RST;
      sysCtrl_q <= `MDS_SYS_RST;
    end else begin
      coilWord_q <= coilWord_d;
      spinRef_q <= spinRef_d;
      sysCtrl_q <= sysCtrl_d;
    end
  end

  // Mode bits
  assign bemfMode = sysCtrl_q[`MDS_SYS_BEMF_MODE];
  assign startMode = sysCtrl_q[`MDS_SYS_START_SEL];

  // The step bit acts on its falling change, whichever path wrote it
  assign stepFall = sysCtrl_q[`MDS_SYS_STEP_BIT] & ~sysCtrl_d[`MDS_SYS_STEP_BIT];

  // External pulse counts on its rising edge only
  assign auxRise = externalCommutationPulse & ~auxPulse_q;

  // Both edges of the phase-crossing signal count
  assign phaseEdge = phaseCrossSignal ^ phaseCross_q;

  // Back-EMF advance source: processor during start, internal loop in run
  assign stateAdvance = bemfMode & (startMode ?
                        (sysCtrl_q[`MDS_SYS_AUX_SOURCE] ? auxRise : stepFall) :
                        phaseEdge);

  // Hall decode; an illegal pattern holds the last good state
  assign hallState = hallDecode({hallInputPhaseThree, hallInputPhaseTwo,
                                 hallInputPhaseOne});

  // Input history; synchronous inputs need no extra stages
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      auxPulse_q <= 1'b0;
      phaseCross_q <= 1'b0;
      hallIllegal_q <= 1'b0;
    end else begin
      auxPulse_q <= externalCommutationPulse;
      phaseCross_q <= phaseCrossSignal;
      hallIllegal_q <= hallState[`MDS_HALL_BAD_BIT];
    end
  end

  // Commutation counter; hall mode follows the sensors with no software
  mds_commutation_step uStep (
    .clk(clk),
    .rstn(rstn),
    .clear(fault),
    .load(~bemfMode & ~hallState[`MDS_HALL_BAD_BIT]),
    .loadState(hallState[2:0]),
    .advance(stateAdvance & ~fault),
    .state_q(commState)
  );

  assign bridge = bridgeTable(commState);
  assign gainSel = gainDecode(coilWord_q[`MDS_GAIN_MSB:`MDS_GAIN_LSB]);

  // DAC steering and gain switches
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dacCode <= 8'h00;
      dacToSpindle <= 1'b0;
      gainSwitchOne <= 1'b0;
      gainSwitchTwo <= 1'b0;
      gainSwitchThree <= 1'b0;
    end else begin
      dacCode <= coilWord_q[`MDS_DAC_MSB:`MDS_DAC_LSB];
      dacToSpindle <= startMode & ~fault;
      gainSwitchOne <= gainSel[0];
      gainSwitchTwo <= gainSel[1];
      gainSwitchThree <= gainSel[2];
    end
  end

  // Coil bridge and retract path; DAC MSB picks the current direction
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      coilOutputAHighOn <= 1'b0;
      coilOutputALowOn <= 1'b0;
      coilOutputBHighOn <= 1'b0;
      coilOutputBLowOn <= 1'b0;
      retractDriveOutputEn <= 1'b0;
      retractDriveLevel <= 1'b0;
      retractActive <= 1'b0;
    end else if (fault) begin
      coilOutputAHighOn <= 1'b0;
      coilOutputALowOn <= 1'b0;
      coilOutputBHighOn <= 1'b0;
      coilOutputBLowOn <= 1'b1;
      retractDriveOutputEn <= 1'b1;
      retractDriveLevel <= retractLevelSet;
      retractActive <= 1'b1;
    end else begin
      // Coil is parked while the DAC feeds spindle start current
      coilOutputAHighOn <= sysCtrl_q[`MDS_SYS_COIL_EN] & ~startMode &
                           coilWord_q[`MDS_DAC_MSB];
      coilOutputALowOn <= sysCtrl_q[`MDS_SYS_COIL_EN] & ~startMode &
                          ~coilWord_q[`MDS_DAC_MSB];
      coilOutputBHighOn <= sysCtrl_q[`MDS_SYS_COIL_EN] & ~startMode &
                           ~coilWord_q[`MDS_DAC_MSB];
      coilOutputBLowOn <= sysCtrl_q[`MDS_SYS_COIL_EN] & ~startMode &
                          coilWord_q[`MDS_DAC_MSB];
      retractDriveOutputEn <= 1'b0;
      retractDriveLevel <= 1'b0;
      retractActive <= 1'b0;
    end
  end

  // Spindle bridge; fault first, then brake, then normal commutation
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spinHighOn <= 3'h0;
      spinLowOn <= 3'h0;
      centerTapControlOut <= 1'b0;
      centerTapControlOeN <= 1'b1;
    end else if (fault) begin
      spinHighOn <= 3'h0;
      spinLowOn <= 3'h0;
      centerTapControlOut <= 1'b0;
      centerTapControlOeN <= 1'b1;
    end else if (sysCtrl_q[`MDS_SYS_BRAKE]) begin
      // Shorting the windings to supply stops the motor
      spinHighOn <= 3'h7;
      spinLowOn <= 3'h0;
      centerTapControlOut <= 1'b0;
      centerTapControlOeN <= 1'b1;
    end else if (sysCtrl_q[`MDS_SYS_SPIN_EN]) begin
      // Unipolar: external transistor lifts the center tap, high sides idle
      spinHighOn <= sysCtrl_q[`MDS_SYS_UNIPOLAR] ? 3'h0 : bridge[5:3];
      spinLowOn <= bridge[2:0];
      centerTapControlOut <= 1'b0;
      centerTapControlOeN <= ~sysCtrl_q[`MDS_SYS_UNIPOLAR];
    end else begin
      spinHighOn <= 3'h0;
      spinLowOn <= 3'h0;
      centerTapControlOut <= 1'b0;
      centerTapControlOeN <= 1'b1;
    end
  end

  // Read multiplexer; the serial routing word reads back as zero
  always @* begin
    rdMux = 32'h0000_0000;
    case (paddr)
      `MDS_OFS_COIL: rdMux[`MDS_COIL_WIDTH-1:0] = coilWord_q;
      `MDS_OFS_SPIN_REF: rdMux[`MDS_SPIN_REF_WIDTH-1:0] = spinRef_q;
      `MDS_OFS_SYS_CTRL: rdMux[`MDS_SYS_WIDTH-1:0] = sysCtrl_q;
      `MDS_OFS_STATUS: begin
        rdMux[`MDS_ST_STATE_MSB:`MDS_ST_STATE_LSB] = commState;
        rdMux[`MDS_ST_HALL_BAD] = hallIllegal_q;
        rdMux[`MDS_ST_FAULT] = fault;
        rdMux[`MDS_ST_RETRACT] = retractActive;
        rdMux[`MDS_ST_GAIN_MSB:`MDS_ST_GAIN_LSB] =
          {gainSwitchThree, gainSwitchTwo, gainSwitchOne};
        rdMux[`MDS_ST_HALL_MSB:`MDS_ST_HALL_LSB] =
          {hallInputPhaseThree, hallInputPhaseTwo, hallInputPhaseOne};
        rdMux[`MDS_ST_DAC_SPIN] = dacToSpindle;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle and stands through access
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (rdSetup) begin
      prdata <= rdMux;
    end
  end

endmodule

// ==== testbench/mds_motor_drive_sequencer_checker.sv ====
// Watches the sequencer's pins for fault, retract and drive-stage relations
module mds_motor_drive_sequencer_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus activity
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  // Supply monitor and retract
  input wire logic powerGoodResetN,
  input wire logic retractLevelSet,
  input wire logic retractDriveOutputEn,
  input wire logic retractDriveLevel,
  input wire logic retractActive,
  // Gain, coil and spindle stages
  input wire logic dacToSpindle,
  input wire logic gainSwitchOne,
  input wire logic gainSwitchTwo,
  input wire logic gainSwitchThree,
  input wire logic coilOutputAHighOn,
  input wire logic coilOutputALowOn,
  input wire logic coilOutputBHighOn,
  input wire logic coilOutputBLowOn,
  input wire logic [2:0] spinHighOn,
  input wire logic [2:0] spinLowOn,
  input wire logic centerTapControlOut,
  input wire logic centerTapControlOeN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Gain switches and retract behaviour
  AST_GAIN_ONE_HOT: assert property (
    $onehot0({gainSwitchThree, gainSwitchTwo, gainSwitchOne}))
    else $error("more than one gain switch closed");
  // A gain change needs a write two edges back, or a fault clearing the word
  AST_GAIN_HOLD: assert property ($changed({gainSwitchThree, gainSwitchTwo, gainSwitchOne})
    |-> $past(psel && penable && pwrite, 2) || $past(!powerGoodResetN, 2)
    || $past(!powerGoodResetN)) else $error("gain switches moved without a write");
  AST_RETRACT_ENTRY: assert property (
    !powerGoodResetN |=> retractActive && retractDriveOutputEn)
    else $error("fault did not start retract");
  AST_RETRACT_COIL: assert property (!powerGoodResetN |=> coilOutputBLowOn
    && !coilOutputBHighOn && !coilOutputAHighOn && !coilOutputALowOn)
    else $error("coil bridge wrong in retract");
  AST_RETRACT_LEVEL: assert property (
    retractActive |-> retractDriveLevel == $past(retractLevelSet))
    else $error("retract level does not follow its set input");
  AST_RETRACT_EXIT: assert property (powerGoodResetN |=> !retractActive)
    else $error("retract held with supply good");
  AST_FAULT_SPIN: assert property (!powerGoodResetN |=> spinHighOn == 3'h0
    && spinLowOn == 3'h0 && !dacToSpindle) else $error("spindle driven during fault");
  // Spindle stage modes
  AST_BRAKE: assert property (spinHighOn == 3'h7 |-> spinLowOn == 3'h0)
    else $error("low side on while all high sides on");
  AST_UNIPOLAR: assert property (!centerTapControlOeN |-> spinHighOn == 3'h0
    && !centerTapControlOut) else $error("high side on while center tap driven");
  AST_START_COIL_OFF: assert property (dacToSpindle |-> !coilOutputAHighOn
    && !coilOutputALowOn) else $error("coil driven during spindle start");
endmodule

bind mds_motor_drive_sequencer mds_motor_drive_sequencer_checker u_chk (.clk(clk), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .powerGoodResetN(powerGoodResetN),
  .retractLevelSet(retractLevelSet), .retractDriveOutputEn(retractDriveOutputEn),
  .retractDriveLevel(retractDriveLevel), .retractActive(retractActive),
  .dacToSpindle(dacToSpindle), .gainSwitchOne(gainSwitchOne), .gainSwitchTwo(gainSwitchTwo),
  .gainSwitchThree(gainSwitchThree), .coilOutputAHighOn(coilOutputAHighOn),
  .coilOutputALowOn(coilOutputALowOn), .coilOutputBHighOn(coilOutputBHighOn),
  .coilOutputBLowOn(coilOutputBLowOn), .spinHighOn(spinHighOn), .spinLowOn(spinLowOn),
  .centerTapControlOut(centerTapControlOut), .centerTapControlOeN(centerTapControlOeN));

// ==== testbench/mds_motor_model.sv ====
// Rotor, hall sensors and processor start pulses seen from the driver
module mds_motor_model (
  // Clock
  input wire logic clk,
  // Toward the driver
  output logic [2:0] hall,
  output logic auxPulse,
  output logic phaseCross
);
  timeunit 1ns;
  timeprecision 1ps;
  // Rotor rests at the first hall position
  initial begin
    hall = 3'h1;
    auxPulse = 1'b0;
    phaseCross = 1'b0;
  end
  // Move the rotor to a new hall position
  task automatic turnHall(input logic [2:0] code);
    @(posedge clk);
    hall <= code;
  endtask
  // Processor start pulses; gap sets the start frequency
  task automatic pulseAux(input int n, input int gap);
    repeat (n) begin
      @(posedge clk);
      auxPulse <= 1'b1;
      @(posedge clk);
      auxPulse <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask
  // Each zero crossing of the filtered phase voltage flips the line
  task automatic crossPhase(input int n, input int gap);
    repeat (n) begin
      @(posedge clk);
      phaseCross <= ~phaseCross;
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule

// ==== testbench/mds_motor_drive_sequencer_bench.sv ====
// Self-checking bench for the motor drive sequencer
module mds_motor_drive_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic pready, pslverr, err;
  logic powerGoodResetN = 1'b1, retractLevelSet = 1'b0;
  logic retractDriveOutputEn, retractDriveLevel, retractActive;
  logic [2:0] hall, spinHighOn, spinLowOn;
  logic externalCommutationPulse, phaseCrossSignal, dacToSpindle;
  logic [7:0] dacCode;
  logic gainSwitchOne, gainSwitchTwo, gainSwitchThree;
  logic coilOutputAHighOn, coilOutputALowOn, coilOutputBHighOn, coilOutputBLowOn;
  logic centerTapControlOut, centerTapControlOeN;
  int n_fail = 0, n_checks = 0, cycles = 0;

  always #2.5 clk = ~clk;

  mds_motor_drive_sequencer u_mds_motor_drive_sequencer (.clk, .rstn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .powerGoodResetN, .retractLevelSet,
    .retractDriveOutputEn, .retractDriveLevel, .retractActive, .hallInputPhaseOne(hall[0]),
    .hallInputPhaseTwo(hall[1]), .hallInputPhaseThree(hall[2]), .externalCommutationPulse,
    .phaseCrossSignal, .dacCode, .dacToSpindle, .gainSwitchOne, .gainSwitchTwo,
    .gainSwitchThree, .coilOutputAHighOn, .coilOutputALowOn, .coilOutputBHighOn,
    .coilOutputBLowOn, .spinHighOn, .spinLowOn, .centerTapControlOut, .centerTapControlOeN);
  mds_motor_model u_mds_motor_model (.clk(clk), .hall(hall),
    .auxPulse(externalCommutationPulse), .phaseCross(phaseCrossSignal));

  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until ready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(32'(err), 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, e);
  endtask
  // Registered outputs land a few edges after a write; sample off the edge
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic test_reset;
    rd(12'h008, 32'hff, 32'h0);
    chk(32'({centerTapControlOeN, spinHighOn, spinLowOn}), 32'h40);
    apb(1'b0, 12'h020, 32'h0);
    chk(32'(err), 32'h1);
    $display("test reset done");
  endtask
  task automatic test_gain;
    for (int g = 0; g < 4; g++) begin
      wr(12'h000, 32'h5a + 32'(g) + 32'(g << 8));
      settle();
      chk(32'({gainSwitchThree, gainSwitchTwo, gainSwitchOne}), 32'(g ? 1 << (g - 1) : 0));
      chk(32'(dacCode), 32'h5a + 32'(g));
    end
    $display("test gain done");
  endtask
  task automatic test_serial;
    wr(12'h00c, 32'h3084);
    settle();
    chk(32'({spinHighOn, spinLowOn}), 32'h38);
    wr(12'h008, 32'h88);
    settle();
    chk(32'({spinHighOn, centerTapControlOeN, centerTapControlOut}), 32'h0);
    wr(12'h00c, 32'h7080);
    settle();
    chk(32'(centerTapControlOeN), 32'h0);
    wr(12'h008, 32'h80);
    settle();
    chk(32'(centerTapControlOeN), 32'h1);
    $display("test serial done");
  endtask
  task automatic test_step;
    wr(12'h008, 32'he1);
    wr(12'h008, 32'hf1);
    wr(12'h008, 32'he1);
    settle();
    rd(12'h010, 32'h7, 32'h1);
    chk(32'({spinHighOn, spinLowOn}), 32'h0c);
    wr(12'h008, 32'hf1);
    settle();
    rd(12'h010, 32'h7, 32'h1);
    wr(12'h00c, 32'h30e1);
    settle();
    rd(12'h010, 32'h7, 32'h2);
    chk(32'({dacToSpindle, coilOutputAHighOn, coilOutputALowOn}), 32'h4);
    $display("test step done");
  endtask
  task automatic test_aux;
    wr(12'h008, 32'he3);
    u_mds_motor_model.pulseAux(4, 3);
    settle();
    rd(12'h010, 32'h7, 32'h0);
    $display("test aux done");
  endtask
  task automatic test_run;
    wr(12'h008, 32'hc1);
    settle();
    chk(32'({dacToSpindle, coilOutputAHighOn, coilOutputALowOn, coilOutputBHighOn,
      coilOutputBLowOn}), 32'h06);
    u_mds_motor_model.crossPhase(3, 0);
    settle();
    rd(12'h010, 32'h7, 32'h3);
    chk(32'({spinHighOn, spinLowOn}), 32'h11);
    $display("test run done");
  endtask
  task automatic test_hall;
    logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    wr(12'h008, 32'h80);
    for (int i = 0; i < 6; i++) begin
      u_mds_motor_model.turnHall(seq[i]);
      settle();
      rd(12'h010, 32'h7, 32'(i));
    end
    u_mds_motor_model.turnHall(3'h0);
    settle();
    rd(12'h010, 32'h7, 32'h5);
    $display("test hall done");
  endtask
  task automatic test_retract;
    wr(12'h008, 32'hc0);
    wr(12'h000, 32'h80);
    @(posedge clk);
    retractLevelSet <= 1'b1;
    powerGoodResetN <= 1'b0;
    settle();
    chk(32'({retractActive, retractDriveOutputEn, retractDriveLevel}), 32'h7);
    chk(32'({coilOutputAHighOn, coilOutputALowOn, coilOutputBHighOn,
      coilOutputBLowOn}), 32'h1);
    rd(12'h010, 32'h30, 32'h30);
    wr(12'h008, 32'h84);
    settle();
    chk(32'({spinHighOn, spinLowOn}), 32'h0);
    @(posedge clk);
    powerGoodResetN <= 1'b1;
    settle();
    rd(12'h008, 32'hff, 32'h0);
    rd(12'h000, 32'h3ff, 32'h0);
    $display("test retract done");
  endtask

  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    test_reset();
    test_gain();
    test_serial();
    test_step();
    test_aux();
    test_run();
    test_hall();
    test_retract();
    complete_run();
  end
endmodule
